// *** hdl/pcs_apb_slave.sv ***
`timescale 1ns/1ps
module pcs_apb_slave (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcs_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // register side
    input wire logic [7:0] low_rd,
    input wire logic [7:0] stat_rd,
    output logic low_wr,
    output logic [7:0] low_wdata
);
    import pcs_pkg::*;

    logic hit_low;
    logic hit_stat;
    logic setup;

    // address decode
    assign hit_low = (paddr == pcs_reg_addr(CNT_LOW_IDX));
    assign hit_stat = (paddr == pcs_reg_addr(STATUS_IDX));
    assign setup = psel && !penable;

    // answer in the first cycle of the access phase, read data caught at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit_low && !hit_stat;
            if (setup) begin
                prdata <= hit_low ? {24'h00_0000, low_rd} : hit_stat ? {24'h00_0000, stat_rd} : 32'h0000_0000;
            end
        end
    end

    // write takes effect at the completing edge only
    assign low_wr = psel && penable && pwrite && pready && hit_low;
    assign low_wdata = pwdata[7:0];
endmodule // pcs_apb_slave

// *** hdl/pcs_phase_gen.sv ***
`timescale 1ns/1ps
module pcs_phase_gen #(
    parameter int PHASES_P = pcs_pkg::PHASES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // phase outputs
    output logic [PHASES_P-1:0] phase_q,
    output logic cycle_end
);
    import pcs_pkg::*;

    generate
        if (PHASES_P < 2) begin : g_bad
            $error("pcs_phase_gen needs at least two phases");
        end
    endgenerate

    // one-hot ring: phases can never overlap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= PHASES_P'(1);
        end else begin
            phase_q <= {phase_q[PHASES_P-2:0], phase_q[PHASES_P-1]};
        end
    end

    // last phase closes the instruction cycle
    assign cycle_end = phase_q[PHASES_P-1];
endmodule // pcs_phase_gen

// *** hdl/pcs_pkg.sv ***
package pcs_pkg;
    // program counter, instruction word and phase count
    localparam int PC_W_MAX = 11;
    localparam int INSTR_W = 14;
    localparam int PHASES = 4;
    // apb address width and register indices; byte address is four times the index
    localparam int APB_AW = 8;
    localparam int STATUS_IDX = 1;
    localparam int CNT_LOW_IDX = 6;
    // status register field positions
    localparam int STAT_PHASE_LSB = 0;
    localparam int STAT_EXT_BIT = 2;
    localparam int STAT_TMR_BIT = 3;
    localparam int STAT_VALID_BIT = 4;
    // fixed vectors
    localparam logic [PC_W_MAX-1:0] VEC_RESET = 11'h000;
    localparam logic [PC_W_MAX-1:0] VEC_EXT = 11'h004;
    localparam logic [PC_W_MAX-1:0] VEC_TMR = 11'h008;
    // source of the next program counter value
    typedef enum logic [2:0] {
        SRC_SEQ, SRC_SKIP, SRC_LOW, SRC_JUMP, SRC_RET, SRC_EXT, SRC_TMR
    } pcs_src_t;

    function automatic logic [APB_AW-1:0] pcs_reg_addr(input int idx);
        pcs_reg_addr = APB_AW'(idx * 4);
    endfunction
endpackage

// *** hdl/pcs_sequencer.sv ***
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module pcs_sequencer #(
    parameter int PC_W = pcs_pkg::PC_W_MAX
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcs_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // program memory
    output logic [PC_W-1:0] imem_addr,
    input wire logic [pcs_pkg::INSTR_W-1:0] imem_data,
    // decoder
    output logic [pcs_pkg::PHASES-1:0] phase_q,
    output logic [pcs_pkg::INSTR_W-1:0] instr_q,
    output logic instr_valid_q,
    input wire logic dec_jump,
    input wire logic dec_call,
    input wire logic dec_ret,
    input wire logic dec_skip,
    input wire logic [pcs_pkg::PC_W_MAX-1:0] dec_target,
    // return stack
    input wire logic [pcs_pkg::PC_W_MAX-1:0] stack_top,
    input wire logic stack_full,
    output logic push_q,
    output logic [PC_W-1:0] push_addr_q,
    output logic pop_q,
    // interrupt requests
    input wire logic int_en,
    input wire logic int_ext_req,
    input wire logic int_tmr_req,
    output logic ack_ext_q,
    output logic ack_tmr_q
);
    import pcs_pkg::*;

    generate
        if (PC_W < 9 || PC_W > PC_W_MAX) begin : g_bad_width
            $error("pcs_sequencer supports a counter of 9 to 11 bits");
        end
    endgenerate

    // wrapping increment within the implemented range
    function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] v);
        pc_inc = v + 1'b1;
    endfunction

    logic cycle_end;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic low_pend_q;
    logic [7:0] low_val_q;
    logic low_wr;
    logic [7:0] low_wdata;
    logic ext_pend_q;
    logic tmr_pend_q;
    logic int_ok;
    logic flush;
    logic [7:0] stat_rd;
    logic [1:0] phase_idx;
    pcs_src_t src;

    // phase ring
    pcs_phase_gen #(
        .PHASES_P(PHASES)
    ) u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .phase_q(phase_q),
        .cycle_end(cycle_end)
    );

    // register port
    pcs_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .low_rd(pc_q[7:0]),
        .stat_rd(stat_rd),
        .low_wr(low_wr),
        .low_wdata(low_wdata)
    );

    // status view of the sequencer
    assign phase_idx = phase_q[3] ? 2'h3 : phase_q[2] ? 2'h2 : phase_q[1] ? 2'h1 : 2'h0;
    always_comb begin
        stat_rd = 8'h00;
        stat_rd[STAT_PHASE_LSB +: 2] = phase_idx;
        stat_rd[STAT_EXT_BIT] = ext_pend_q;
        stat_rd[STAT_TMR_BIT] = tmr_pend_q;
        stat_rd[STAT_VALID_BIT] = instr_valid_q;
    end

    // interrupts wait while the stack is full or a dummy cycle runs
    // a dummy cycle already replaces a word, so vectoring waits for a real one
    assign int_ok = int_en && !stack_full && instr_valid_q;

    // next counter source; a pending low byte write wins over the decoder
    assign src = low_pend_q ? SRC_LOW :
                 (instr_valid_q && (dec_jump || dec_call)) ? SRC_JUMP :
                 (instr_valid_q && dec_ret) ? SRC_RET :
                 (instr_valid_q && dec_skip) ? SRC_SKIP :
                 (int_ok && ext_pend_q) ? SRC_EXT :
                 (int_ok && tmr_pend_q) ? SRC_TMR : SRC_SEQ;
    assign flush = (src != SRC_SEQ);

    // next counter value
    always_comb begin
        case (src)
            SRC_SEQ: pc_d = pc_inc(pc_q);
            SRC_SKIP: pc_d = pc_inc(pc_q);
            SRC_LOW: pc_d = {pc_q[PC_W-1:8], low_val_q};
            SRC_JUMP: pc_d = dec_target[PC_W-1:0];
            SRC_RET: pc_d = stack_top[PC_W-1:0];
            SRC_EXT: pc_d = VEC_EXT[PC_W-1:0];
            SRC_TMR: pc_d = VEC_TMR[PC_W-1:0];
            default: pc_d = pc_inc(pc_q);
        endcase
    end

    // counter moves only at the end of an instruction cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= VEC_RESET[PC_W-1:0];
        end else if (cycle_end) begin
            pc_q <= pc_d;
        end
    end
    assign imem_addr = pc_q;

    // fetch pipe; a flushed prefetch becomes the dummy cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_q <= '0;
            instr_valid_q <= 1'b0;
        end else if (cycle_end) begin
            instr_q <= imem_data;
            instr_valid_q <= !flush;
        end
    end

    // low byte write held until the cycle boundary; a new write wins
    // limitation: two writes inside one cycle apply only the later value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_pend_q <= 1'b0;
            low_val_q <= 8'h00;
        end else if (low_wr) begin
            low_pend_q <= 1'b1;
            low_val_q <= low_wdata;
        end else if (cycle_end) begin
            low_pend_q <= 1'b0;
        end
    end

    // pending interrupts: a request in the ack cycle is not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pend_q <= 1'b0;
            tmr_pend_q <= 1'b0;
        end else begin
            ext_pend_q <= int_ext_req || (ext_pend_q && !(cycle_end && src == SRC_EXT));
            tmr_pend_q <= int_tmr_req || (tmr_pend_q && !(cycle_end && src == SRC_TMR));
        end
    end

    // stack strobes: the return address is the discarded prefetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            push_q <= 1'b0;
            pop_q <= 1'b0;
            push_addr_q <= '0;
            ack_ext_q <= 1'b0;
            ack_tmr_q <= 1'b0;
        end else begin
            push_q <= cycle_end && ((src == SRC_JUMP && dec_call) || src == SRC_EXT || src == SRC_TMR);
            pop_q <= cycle_end && src == SRC_RET;
            ack_ext_q <= cycle_end && src == SRC_EXT;
            ack_tmr_q <= cycle_end && src == SRC_TMR;
            if (cycle_end) begin
                push_addr_q <= pc_q;
            end
        end
    end

    // checks
    AST_PHASE_ONEHOT: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot(phase_q)) else $error("phases overlap or vanish");

    AST_CYCLE_FOUR: assert property (@(posedge pclk) disable iff (!presetn)
        cycle_end |=> (!cycle_end)[*3] ##1 cycle_end) else $error("cycle is not four clocks");

    AST_FETCH_PIPE: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && !flush) |=> instr_valid_q && instr_q == $past(imem_data))
        else $error("fetched word not passed to decode");

    AST_TRANSFER_DUMMY: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && flush) |=> (!instr_valid_q)[*4] ##1 instr_valid_q)
        else $error("transfer without exactly one dummy cycle");

    AST_SEQ_INC: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && src == SRC_SEQ) |=> pc_q == pc_inc($past(pc_q)))
        else $error("sequential fetch did not add one");

    AST_SKIP_PLUS2: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && src == SRC_SKIP) |=> ##4 instr_valid_q && pc_q == pc_inc(pc_inc($past(pc_q, 5))))
        else $error("skip did not resume two past the skipped word");

    AST_LOW_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && src == SRC_LOW) |=> pc_q[7:0] == $past(low_val_q) && pc_q[PC_W-1:8] == $past(pc_q[PC_W-1:8]))
        else $error("low byte write left its page");

    AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && (src == SRC_EXT || src == SRC_TMR))
        |=> pc_q == ((ack_ext_q ? VEC_EXT[PC_W-1:0] : VEC_TMR[PC_W-1:0])) && push_q)
        else $error("wrong interrupt vector");

    AST_JUMP_RET: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && (src == SRC_JUMP || src == SRC_RET))
        |=> pc_q == ($past(src == SRC_RET) ? $past(stack_top[PC_W-1:0]) : $past(dec_target[PC_W-1:0])))
        else $error("jump or return loaded wrong address");

    AST_FULL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && stack_full) |-> src != SRC_EXT && src != SRC_TMR)
        else $error("interrupt taken with full stack");

    AST_PUSH_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && (src == SRC_EXT || src == SRC_TMR || (src == SRC_JUMP && dec_call)))
        |=> push_q && push_addr_q == $past(pc_q))
        else $error("return address is not the discarded prefetch");

    AST_RET_POP: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && src == SRC_RET) |=> pop_q && !push_q)
        else $error("return did not pop the stack");

    AST_PC_STILL: assert property (@(posedge pclk) disable iff (!presetn)
        !cycle_end |=> $stable(pc_q))
        else $error("counter moved inside an instruction cycle");

    AST_INSTR_STILL: assert property (@(posedge pclk) disable iff (!presetn)
        !cycle_end |=> $stable(instr_q) && $stable(instr_valid_q))
        else $error("decode word changed inside an instruction cycle");

    AST_EXT_HELD: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_pend_q && !(cycle_end && src == SRC_EXT)) |=> ext_pend_q)
        else $error("pending external request lost");

    AST_TMR_HELD: assert property (@(posedge pclk) disable iff (!presetn)
        (tmr_pend_q && !(cycle_end && src == SRC_TMR)) |=> tmr_pend_q)
        else $error("pending timer request lost");

    AST_ACK_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        (ack_ext_q || ack_tmr_q) |=> !ack_ext_q && !ack_tmr_q && !push_q)
        else $error("vector strobe longer than one clock");

    AST_LOW_TAKEN: assert property (@(posedge pclk) disable iff (!presetn)
        low_wr |=> low_pend_q && low_val_q == $past(low_wdata))
        else $error("low byte write not held for the cycle end");

    AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("register answer longer than one clock");

    AST_VALID_RESUME: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && !instr_valid_q && !low_pend_q) |=> instr_valid_q)
        else $error("dummy cycle lasted more than one cycle");

    AST_INT_GATED: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && (src == SRC_EXT || src == SRC_TMR)) |-> int_en && instr_valid_q)
        else $error("interrupt taken while disabled or in a dummy cycle");

    // main scenarios worth reaching
    COV_SKIP: cover property (@(posedge pclk) disable iff (!presetn) cycle_end && src == SRC_SKIP);
    COV_CALL_RET: cover property (@(posedge pclk) disable iff (!presetn) push_q ##[1:40] pop_q);
    COV_HELD_INT: cover property (@(posedge pclk) disable iff (!presetn) ext_pend_q && stack_full ##[1:40] ack_ext_q);
    COV_LOW_WRITE: cover property (@(posedge pclk) disable iff (!presetn) cycle_end && src == SRC_LOW);
    COV_TMR_VECTOR: cover property (@(posedge pclk) disable iff (!presetn) ack_tmr_q);
endmodule // pcs_sequencer

// *** sim/pcs_prog_model.sv ***
`timescale 1ns/1ps
module pcs_prog_model #(
    parameter int PC_W = 11
) (
    // clock
    input wire logic pclk,
    // fetch and decode
    input wire logic [PC_W-1:0] imem_addr,
    output logic [pcs_pkg::INSTR_W-1:0] imem_data,
    input wire logic [pcs_pkg::INSTR_W-1:0] instr_q,
    input wire logic instr_valid_q,
    output logic dec_jump,
    output logic dec_call,
    output logic dec_ret,
    output logic dec_skip,
    output logic [pcs_pkg::PC_W_MAX-1:0] dec_target,
    // return stack
    input wire logic push_q,
    input wire logic [PC_W-1:0] push_addr_q,
    output logic [pcs_pkg::PC_W_MAX-1:0] stack_top
);
    import pcs_pkg::*;
    logic [INSTR_W-1:0] mem [0:2047];
    logic [PC_W_MAX-1:0] ret_q;
    logic [2:0] op;
    // opcode in the top three bits; skip words always meet their condition
    assign imem_data = mem[PC_W_MAX'(imem_addr)];
    assign op = instr_q[13:11];
    assign dec_jump = instr_valid_q && (op == 3'h1);
    assign dec_call = instr_valid_q && (op == 3'h2);
    assign dec_ret = instr_valid_q && (op == 3'h3);
    assign dec_skip = instr_valid_q && (op == 3'h4);
    assign dec_target = instr_q[10:0];
    assign stack_top = ret_q;
    // one level only, the bench never nests calls
    always_ff @(posedge pclk) begin
        if (push_q) begin
            ret_q <= PC_W_MAX'(push_addr_q);
        end
    end
endmodule // pcs_prog_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
    import pcs_pkg::*;
    localparam int PCW = 9;
    typedef struct {logic [10:0] a; int g;} pcs_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [PCW-1:0] imem_addr, push_addr_q;
    logic [INSTR_W-1:0] imem_data, instr_q;
    logic [PHASES-1:0] phase_q;
    logic instr_valid_q, dec_jump, dec_call, dec_ret, dec_skip, push_q;
    logic pop_q, ack_ext_q, ack_tmr_q;
    logic [PC_W_MAX-1:0] dec_target, stack_top;
    logic stack_full = 1'b0;
    logic int_en = 1'b1;
    logic int_ext_req = 1'b0;
    logic int_tmr_req = 1'b0;
    int n_errors = 0;
    int n_tests = 0;
    int n_push = 0, n_pop = 0, n_ext = 0, n_tmr = 0;
    // executed address and cycle ends since the previous one
    pcs_row_t rows [8] = '{'{11'h001, 1}, '{11'h010, 2}, '{11'h012, 2}, '{11'h020, 2},
        '{11'h013, 2}, '{11'h014, 1}, '{11'h1f8, 2}, '{11'h1f9, 1}};

    always #20 pclk = ~pclk;

    // stack and vector strobes counted as the far side sees them
    always @(posedge pclk) begin
        if (push_q === 1'b1) n_push++;
        if (pop_q === 1'b1) n_pop++;
        if (ack_ext_q === 1'b1) n_ext++;
        if (ack_tmr_q === 1'b1) n_tmr++;
    end

    pcs_sequencer #(.PC_W(PCW)) pcs_sequencer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .imem_addr, .imem_data, .phase_q, .instr_q, .instr_valid_q,
        .dec_jump, .dec_call, .dec_ret, .dec_skip, .dec_target, .stack_top, .stack_full, .push_q,
        .push_addr_q, .pop_q, .int_en, .int_ext_req, .int_tmr_req, .ack_ext_q, .ack_tmr_q);

    pcs_prog_model #(.PC_W(PCW)) pcs_prog_model_i (.pclk, .imem_addr, .imem_data, .instr_q,
        .instr_valid_q, .dec_jump, .dec_call, .dec_ret, .dec_skip, .dec_target, .push_q,
        .push_addr_q, .stack_top);

    // program: jump, skip, call, return, far jump with bits above the width
    function automatic logic [13:0] prog(input logic [10:0] a);
        case (a)
            11'h001: prog = {3'h1, 11'h010};
            11'h010: prog = {3'h4, 11'h010};
            11'h012: prog = {3'h2, 11'h020};
            11'h020: prog = {3'h3, 11'h020};
            11'h014: prog = {3'h1, 11'h7f8};
            11'h141: prog = {3'h1, 11'h7ff};
            default: prog = {3'h0, a};
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        chk(n < 20, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // waits for the next executed word, counting cycle ends on the way
    task automatic nxt(input logic [10:0] a, input int g);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            if (phase_q === 4'b0001) n++;
        end while (!(phase_q === 4'b0001 && instr_valid_q === 1'b1) && n < 4);
        chk(n, g);
        chk(instr_q, prog(a));
    endtask

    task automatic pulse(input logic t);
        @(posedge pclk);
        int_ext_req <= !t;
        int_tmr_req <= t;
        @(posedge pclk);
        int_ext_req <= 1'b0;
        int_tmr_req <= 1'b0;
    endtask

    task automatic rst;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        #1;
        chk(phase_q, 4'b0001);
        chk(imem_addr, 0);
        chk(instr_valid_q, 0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h18, 8'h00);
        chk(rd, 0);
        #1;
        chk(phase_q, 4'b1000);
        nxt(11'h000, 1);
    endtask

    task automatic results;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 3000);
        n_errors++;
        results();
    end

    initial begin
        for (int i = 0; i < 2048; i++) begin
            pcs_prog_model_i.mem[i] = prog(11'(i));
        end
        rst();
        foreach (rows[i]) begin
            nxt(rows[i].a, rows[i].g);
        end
        apb(1'b0, 8'h18, 8'h00);
        chk(rd, 32'h0000_00fa);
        nxt(11'h1fa, 1);
        apb(1'b1, 8'h18, 8'h40);
        nxt(11'h140, 2);
        nxt(11'h141, 1);
        nxt(11'h1ff, 2);
        nxt(11'h000, 1);
        pulse(1'b0);
        nxt(11'h004, 2);
        pulse(1'b1);
        nxt(11'h008, 2);
        @(posedge pclk);
        stack_full <= 1'b1;
        pulse(1'b0);
        nxt(11'h009, 1);
        apb(1'b0, 8'h04, 8'h00);
        chk(rd, 32'h0000_0015);
        nxt(11'h00a, 1);
        @(posedge pclk);
        stack_full <= 1'b0;
        nxt(11'h004, 2);
        @(posedge pclk);
        int_en <= 1'b0;
        pulse(1'b1);
        nxt(11'h005, 1);
        @(posedge pclk);
        int_en <= 1'b1;
        nxt(11'h008, 2);
        apb(1'b0, 8'h1c, 8'h00);
        chk(err, 1'b1);
        chk(rd, 0);
        chk(n_push, 5);
        chk(n_pop, 1);
        chk(n_ext, 2);
        chk(n_tmr, 2);
        rst();
        results();
    end
endmodule // tb
